// ==== rtl/chsc_pkg.sv ====
package chsc_pkg;

    // ****************************************************************
    // Lower status word layout (bit 0 is the most significant)
    // ****************************************************************
    localparam int LSW_W          = 32;
    localparam int BIT_ECHO       = 0;
    localparam int BIT_PPI        = 1;
    localparam int BIT_INCLEN     = 2;
    localparam int BIT_PGMCHK     = 3;
    localparam int BIT_DATACHK    = 4;
    localparam int BIT_CTLCHK     = 5;
    localparam int BIT_IFCHK      = 6;
    localparam int BIT_CHAINCHK   = 7;
    localparam int BIT_BUSY       = 8;
    localparam int BIT_STMOD      = 9;
    localparam int BIT_CTLEND     = 10;
    localparam int BIT_DEVEND     = 13;
    localparam int RESID_LO       = 16;
    localparam int RESID_HI       = 31;
    localparam int COUNT_W        = 16;

    // ****************************************************************
    // Constants
    // ****************************************************************
    localparam logic [23:0] CCD_STEP_SKIP   = 24'h000010;
    localparam logic [15:0] COUNT_ZERO      = 16'h0000;
    localparam logic [15:0] RESET_STATUS    = 16'h0000;
    localparam logic [3:0]  CMD_LOW_ZERO    = 4'h0;
    localparam logic [1:0]  WORD_ALIGN_MASK = 2'h3;

    typedef enum logic [1:0] {
        CHSC_OP_READ    = 2'b00,
        CHSC_OP_WRITE   = 2'b01,
        CHSC_OP_CONTROL = 2'b10,
        CHSC_OP_SENSE   = 2'b11
    } chsc_op_e;

    // Descriptor as held by the subchannel
    typedef struct packed {
        logic [23:0] addr;
        logic [3:0]  cmd_low;
        logic        is_tic;
        logic        first;
        logic        data_chain;
        logic        cmd_chain;
        logic        sup_len;
        logic        ppi_flag;
        logic [15:0] count;
    } chsc_ccd_s;

    // Controller status as received
    typedef struct packed {
        logic busy;
        logic stmod;
        logic ctlend;
        logic attn;
        logic chend;
        logic devend;
        logic ucheck;
        logic uexcp;
    } chsc_dev_s;

endpackage

// ==== rtl/chsc_len_check.sv ====
`timescale 1ns/10ps
// Byte-count tracking and incorrect-length decision
module chsc_len_check
    import chsc_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic              load,
    input  wire logic [15:0]       load_count,
    input  wire logic              byte_req,
    input  wire logic              dev_term,
    output logic                   byte_grant,
    output logic                   inclen,
    output logic [15:0]            residual,
    output logic                   count_zero
);

    logic [15:0] count_q;
    logic        long_q;

    assign count_zero = (count_q == COUNT_ZERO);
    assign byte_grant = byte_req && !count_zero;
    assign residual   = count_q;
    // Short block: leftover count at termination
    assign inclen     = long_q || (dev_term && !count_zero);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            count_q <= COUNT_ZERO;
        end else if (load) begin
            count_q <= load_count;
        end else if (byte_grant) begin
            count_q <= count_q - 16'h0001;
        end
    end

    // Long block remembered, residual stays zero
    always_ff @(posedge sys_clk) begin
        if (sys_rst || load) begin
            long_q <= 1'b0;
        end else if (byte_req && count_zero) begin
            long_q <= 1'b1;
        end
    end

endmodule

// ==== rtl/chsc_core.sv ====
`timescale 1ns/10ps
module chsc_core
    import chsc_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire chsc_ccd_s         ccd,
    input  wire logic              ccd_load,
    input  wire chsc_op_e          op,
    input  wire logic              ctl_facility,
    input  wire logic              fetch_fail,
    input  wire logic              ccd_parity_err,
    input  wire logic              tic_to_tic,
    input  wire logic              ctl_malfunction,
    input  wire logic              mem_fail,
    input  wire logic              mem_parity_err,
    input  wire logic              if_parity_err,
    input  wire logic              if_seq_err,
    input  wire logic              byte_req,
    input  wire logic              dev_valid,
    input  wire chsc_dev_s         dev,
    input  wire logic              instr_answer,
    input  wire logic              ppi_ack,
    output logic                   byte_grant,
    output logic                   status_valid,
    output logic [LSW_W-1:0]       status_word,
    output logic                   chain_go,
    output logic [23:0]            chain_addr,
    output logic                   terminate,
    output logic                   ppi_pending
);

    // ****************************************************************
    // Condition capture
    // ****************************************************************
    chsc_ccd_s   ccd_q;
    logic        pgm_q, data_q, ctl_q, if_q;
    logic        byte_grant_q, status_valid_q, chain_go_q, terminate_q, ppi_q;
    logic [23:0] chain_addr_q;
    logic [LSW_W-1:0] status_q;
    logic        grant_c, inclen_c, cnt_zero_c;
    logic [15:0] resid_c;
    logic        dev_term;
    logic        unusual;
    logic        inclen_stops;
    logic        pgm_ev;
    logic        stmod_only;
    logic [LSW_W-1:0] status_d;

    assign dev_term = dev_valid && (dev.chend || dev.devend);

    chsc_len_check u_len (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .load       (ccd_load),
        .load_count (ccd.count),
        .byte_req   (byte_req),
        .dev_term   (dev_term),
        .byte_grant (grant_c),
        .inclen     (inclen_c),
        .residual   (resid_c),
        .count_zero (cnt_zero_c)
    );

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ccd_q <= '0;
        end else if (ccd_load) begin
            ccd_q <= ccd;
        end
    end

    assign pgm_ev = (ccd_load && (
                        ((ccd.addr[1:0] & WORD_ALIGN_MASK) != 2'h0) ||
                        (ccd.cmd_low == CMD_LOW_ZERO && !ctl_facility && !ccd.is_tic) ||
                        (ccd.count == COUNT_ZERO && !ccd.is_tic) ||
                        (ccd.is_tic && ccd.first)))
                    || fetch_fail || mem_fail || tic_to_tic;

    // Flags hold until the next descriptor load; an event in that cycle wins
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pgm_q  <= 1'b0;
            data_q <= 1'b0;
            ctl_q  <= 1'b0;
            if_q   <= 1'b0;
        end else begin
            pgm_q  <= pgm_ev || (pgm_q && !ccd_load);
            // Data check kept until the next descriptor load
            data_q <= mem_parity_err || (data_q && !ccd_load);
            ctl_q  <= ctl_malfunction || ccd_parity_err || (ctl_q && !ccd_load);
            if_q   <= if_parity_err || if_seq_err || (if_q && !ccd_load);
        end
    end

    // ****************************************************************
    // Post-program interrupt
    // ****************************************************************
    // Single pending slot, set wins over acknowledge
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ppi_q <= 1'b0;
        end else if (ccd_q.ppi_flag && ((ccd_q.data_chain && grant_c && resid_c == 16'h0001)
                     || (ccd_q.cmd_chain && dev_valid && dev.devend))) begin
            ppi_q <= 1'b1;
        end else if (ppi_ack) begin
            ppi_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Chaining decision
    // ****************************************************************
    // Incorrect length blocks chaining unless excused
    assign inclen_stops = inclen_c && !ccd_q.sup_len && (op != CHSC_OP_CONTROL);
    assign unusual = pgm_q || data_q || ctl_q || if_q || inclen_stops
                     || dev.ucheck || dev.uexcp || dev.attn || dev.busy;
    // Modifier alone in answer to an instruction
    assign stmod_only = dev_valid && instr_answer && dev.stmod && !dev.busy && !dev.ctlend
                        && !dev.attn && !dev.chend && !dev.devend && !dev.ucheck && !dev.uexcp;

    always_comb begin
        status_d = '0;
        if (stmod_only) begin
            status_d[LSW_W-1-BIT_STMOD] = 1'b1;
        end else begin
            status_d[LSW_W-1-BIT_ECHO]     = 1'b0;
            status_d[LSW_W-1-BIT_PPI]      = ppi_q;
            status_d[LSW_W-1-BIT_INCLEN]   = inclen_c;
            status_d[LSW_W-1-BIT_PGMCHK]   = pgm_q;
            status_d[LSW_W-1-BIT_DATACHK]  = data_q;
            // A terminating event posts in its own cycle, so it is shown before its flag lands
            status_d[LSW_W-1-BIT_CTLCHK]   = ctl_q || ctl_malfunction || ccd_parity_err;
            status_d[LSW_W-1-BIT_IFCHK]    = if_q || if_parity_err || if_seq_err;
            status_d[LSW_W-1-BIT_CHAINCHK] = 1'b0;
            // Controller conditions in the second byte
            status_d[LSW_W-1-BIT_BUSY -: 8] = dev;
            status_d[LSW_W-1-RESID_LO -: COUNT_W] = resid_c;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            status_valid_q <= 1'b0;
            status_q       <= '0;
            chain_go_q     <= 1'b0;
            chain_addr_q   <= '0;
            terminate_q    <= 1'b0;
        end else begin
            status_valid_q <= 1'b0;
            chain_go_q     <= 1'b0;
            terminate_q    <= 1'b0;
            if (ctl_malfunction || ccd_parity_err || if_parity_err || if_seq_err) begin
                terminate_q    <= 1'b1;
                status_valid_q <= 1'b1;
                status_q       <= status_d;
            end else if (stmod_only) begin
                status_valid_q <= 1'b1;
                status_q       <= status_d;
            end else if (dev_valid && dev.devend && ccd_q.cmd_chain && !unusual) begin
                chain_go_q <= 1'b1;
                // Skip one descriptor on modifier
                if (dev.stmod) begin
                    chain_addr_q <= ccd_q.addr + CCD_STEP_SKIP;
                end else begin
                    chain_addr_q <= ccd_q.addr + 24'h000008;
                end
            end else if (dev_valid && (dev.devend || dev.chend)) begin
                status_valid_q <= 1'b1;
                status_q       <= status_d;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            byte_grant_q <= 1'b0;
        end else begin
            byte_grant_q <= grant_c;
        end
    end

    assign byte_grant   = byte_grant_q;
    assign status_valid = status_valid_q;
    assign status_word  = status_q;
    assign chain_go     = chain_go_q;
    assign chain_addr   = chain_addr_q;
    assign terminate    = terminate_q;
    assign ppi_pending  = ppi_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_echo_clear;
        @(posedge sys_clk) disable iff (sys_rst)
        status_valid |-> !status_word[LSW_W-1-BIT_ECHO];
    endproperty
    a_echo_clear: assert property (p_echo_clear) else $error("echo bit set");

    property p_chain_chk_clear;
        @(posedge sys_clk) disable iff (sys_rst)
        status_valid |-> !status_word[LSW_W-1-BIT_CHAINCHK];
    endproperty
    a_chain_chk_clear: assert property (p_chain_chk_clear) else $error("chain check set");

    property p_stmod_only;
        @(posedge sys_clk) disable iff (sys_rst)
        stmod_only && !ctl_malfunction && !ccd_parity_err && !if_parity_err && !if_seq_err
        |=> status_valid && status_word == 32'h00400000;
    endproperty
    a_stmod_only: assert property (p_stmod_only) else $error("modifier-only status wrong");

    property p_skip;
        @(posedge sys_clk) disable iff (sys_rst)
        chain_go && $past(dev.stmod) |-> chain_addr == $past(ccd_q.addr) + 24'h000010;
    endproperty
    a_skip: assert property (p_skip) else $error("skip address wrong");

    property p_ctl_term;
        @(posedge sys_clk) disable iff (sys_rst)
        ctl_malfunction |=> terminate && !chain_go;
    endproperty
    a_ctl_term: assert property (p_ctl_term) else $error("control check not terminating");

    property p_if_term;
        @(posedge sys_clk) disable iff (sys_rst)
        (if_parity_err || if_seq_err) |=> terminate ##1 status_word[LSW_W-1-BIT_IFCHK];
    endproperty
    a_if_term: assert property (p_if_term) else $error("interface check missing");

    property p_no_long_grant;
        @(posedge sys_clk) disable iff (sys_rst)
        (byte_req && cnt_zero_c && !ccd_load) |=> !byte_grant;
    endproperty
    a_no_long_grant: assert property (p_no_long_grant) else $error("byte past count");

    property p_inclen_chain;
        @(posedge sys_clk) disable iff (sys_rst)
        chain_go |-> !$past(inclen_stops);
    endproperty
    a_inclen_chain: assert property (p_inclen_chain) else $error("chained on length");

    property p_data_chk;
        @(posedge sys_clk) disable iff (sys_rst)
        mem_parity_err && !ccd_load ##1 dev_valid && dev.devend |=> !chain_go;
    endproperty
    a_data_chk: assert property (p_data_chk) else $error("chained after data check");

endmodule

// ==== verif/chsc_ctl_model.sv ====
`timescale 1ns/10ps
// ****************************************************************
// Peripheral controller model on the far side of the channel
// ****************************************************************
module chsc_ctl_model
    import chsc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       start,
    input  wire logic       slow,
    input  wire logic [4:0] n_bytes,
    input  wire chsc_dev_s  st,
    input  wire logic       answer,
    output logic            byte_req,
    output logic            dev_valid,
    output chsc_dev_s       dev,
    output logic            instr_answer,
    output logic            busy
);
    chsc_dev_s r;
    logic      asked_q;

    initial begin
        byte_req = 1'b0;
        dev_valid = 1'b0;
        dev = '0;
        instr_answer = 1'b0;
        busy = 1'b0;
        asked_q = 1'b0;
    end

    // Busy is raised on the edge itself so the bench never races it
    always begin
        @(posedge sys_clk);
        if (start) begin
            busy = 1'b1;
            r = st;
            #1;
            for (int k = 0; k < n_bytes; k++) begin
                byte_req = 1'b1;
                @(posedge sys_clk);
                #1;
                if (slow) begin
                    byte_req = 1'b0;
                    @(posedge sys_clk);
                    #1;
                end
            end
            byte_req = 1'b0;
            if (r.busy)
                r.stmod = 1'b1;
            if (!(r.busy || r.ucheck || asked_q))
                r.ctlend = 1'b0;
            asked_q = r.busy && !r.ctlend;
            dev = r;
            dev_valid = 1'b1;
            instr_answer = answer;
            @(posedge sys_clk);
            busy = 1'b0;
            #1;
            dev_valid = 1'b0;
            // Released lines show the inverse so a stale sample cannot pass
            dev = ~r;
            instr_answer = ~answer;
        end
    end
endmodule

// ==== verif/test_channel_status_conditions.sv ====
`timescale 1ns/10ps
module test_channel_status_conditions
    import chsc_pkg::*;
;
    logic        sys_clk, sys_rst, ccd_load, ctl_facility, ppi_ack;
    chsc_ccd_s   ccd;
    chsc_op_e    op;
    logic [7:0]  evp;
    logic        byte_req, dev_valid, instr_answer, byte_grant, status_valid;
    logic        chain_go, terminate, ppi_pending;
    logic [31:0] status_word;
    logic [23:0] chain_addr;
    chsc_dev_s   dev, p_st;
    logic        p_start, p_slow, p_ans, p_busy, sv_seen, cg_seen, tm_seen;
    logic [4:0]  p_n;
    int          n_mismatch, samples_checked, cycles, ngrant;
    int          seed = 56;

    // ****************************************************************
    // Design, partner and clock
    // ****************************************************************
    chsc_core uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .ccd(ccd), .ccd_load(ccd_load),
        .op(op), .ctl_facility(ctl_facility), .fetch_fail(evp[0]),
        .ccd_parity_err(evp[1]), .tic_to_tic(evp[2]), .ctl_malfunction(evp[3]),
        .mem_fail(evp[4]), .mem_parity_err(evp[5]), .if_parity_err(evp[6]),
        .if_seq_err(evp[7]), .byte_req(byte_req), .dev_valid(dev_valid), .dev(dev),
        .instr_answer(instr_answer), .ppi_ack(ppi_ack), .byte_grant(byte_grant),
        .status_valid(status_valid), .status_word(status_word), .chain_go(chain_go),
        .chain_addr(chain_addr), .terminate(terminate), .ppi_pending(ppi_pending));

    chsc_ctl_model ctl (.sys_clk(sys_clk), .start(p_start), .slow(p_slow), .n_bytes(p_n),
        .st(p_st), .answer(p_ans), .byte_req(byte_req), .dev_valid(dev_valid), .dev(dev),
        .instr_answer(instr_answer), .busy(p_busy));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (byte_grant === 1'b1) ngrant++;
        if (status_valid === 1'b1) sv_seen = 1'b1;
        if (chain_go === 1'b1) cg_seen = 1'b1;
        if (terminate === 1'b1) tm_seen = 1'b1;
        if (cycles == 5000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    // ****************************************************************
    // Tasks and expectations
    // ****************************************************************
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask

    task automatic chk1(logic g, logic e);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk32(logic [31:0] g, logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    function automatic logic [15:0] exp_resid(int cnt, int n);
        return (n < cnt) ? 16'(cnt - n) : 16'h0000;
    endfunction

    function automatic logic exp_chain(chsc_ccd_s c, chsc_op_e o, logic il);
        return c.cmd_chain && (!il || c.sup_len || o == CHSC_OP_CONTROL);
    endfunction

    // Load, pulse one event, let the controller move bytes and report
    task automatic run(chsc_ccd_s c, chsc_op_e o, int n, logic [7:0] st, logic ans,
                       logic [7:0] ev, logic ld);
        int k;
        sv_seen = 1'b0;
        cg_seen = 1'b0;
        tm_seen = 1'b0;
        ngrant = 0;
        ccd = c;
        op = o;
        ccd_load = ld;
        tick();
        ccd_load = 1'b0;
        evp = ev;
        tick();
        evp = 8'h00;
        p_n = 5'(n);
        p_st = st;
        p_ans = ans;
        p_slow = 1'($random(seed));
        p_start = 1'b1;
        tick();
        p_start = 1'b0;
        k = 0;
        while (p_busy && k < 40) begin
            tick();
            k++;
        end
        repeat (3) tick();
    endtask

    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        chsc_ccd_s   c;
        chsc_op_e    o;
        logic [31:0] r, r2;
        int          n, cnt, b;
        logic        il;
        logic [7:0]  ev;
        sys_rst = 1'b1;
        ccd = '0;
        ccd_load = 1'b0;
        op = CHSC_OP_READ;
        ctl_facility = 1'b1;
        evp = 8'h00;
        ppi_ack = 1'b0;
        p_start = 1'b0;
        p_slow = 1'b0;
        p_n = 5'h00;
        p_st = '0;
        p_ans = 1'b0;
        repeat (10) tick();
        sys_rst = 1'b0;
        chk32(status_word, 32'h00000000);
        chk1(ppi_pending, 1'b0);
        repeat (40) begin
            r = $random(seed);
            r2 = $random(seed);
            c = '0;
            c.addr = {r[23:2], 2'b00};
            c.cmd_low = r[27:24];
            cnt = 1 + int'(r[30:28]);
            c.count = 16'(cnt);
            c.cmd_chain = r2[2];
            c.sup_len = r2[3];
            o = chsc_op_e'(r2[1:0]);
            n = int'(r2[7:4]) % 10;
            run(c, o, n, 8'h0c, 1'b0, 8'h00, 1'b1);
            il = (n != cnt);
            chk32(32'(ngrant), 32'((n < cnt) ? n : cnt));
            if (exp_chain(c, o, il)) begin
                chk1(cg_seen, 1'b1);
                chk32({8'h00, chain_addr}, {8'h00, c.addr + 24'h000008});
            end else begin
                chk1(cg_seen, 1'b0);
                chk1(sv_seen, 1'b1);
                chk32({16'h0000, status_word[15:0]}, {16'h0000, exp_resid(cnt, n)});
                chk1(status_word[29], il);
                chk1(status_word[31], 1'b0);
                chk1(status_word[24], 1'b0);
            end
        end
        $display("test random transfers done");
        for (int e = 1; e <= 12; e++) begin
            c = '0;
            c.addr = 24'h000100;
            c.cmd_low = 4'h1;
            c.count = 16'h0002;
            c.cmd_chain = (e >= 8);
            ev = 8'h00;
            ctl_facility = (e != 3);
            case (e)
                1: c.addr[1:0] = 2'h2;
                2: ev = 8'h01;
                3: c.cmd_low = 4'h0;
                4: c.count = 16'h0000;
                5: ev = 8'h10;
                6: c.is_tic = 1'b1;
                7: ev = 8'h04;
                8: ev = 8'h20;
                9: ev = 8'h02;
                10: ev = 8'h08;
                11: ev = 8'h40;
                default: ev = 8'h80;
            endcase
            c.first = (e == 6);
            run(c, CHSC_OP_READ, 2, 8'h0c, 1'b0, ev, 1'b1);
            b = (e < 8) ? 28 : (e == 8) ? 27 : (e < 11) ? 26 : 25;
            chk1(status_word[b], 1'b1);
            chk1(cg_seen, 1'b0);
            if (e > 8) chk1(tm_seen, 1'b1);
            if (e == 8) chk1(sv_seen, 1'b1);
            if (e == 8) chk32(32'(ngrant), 32'h2);
        end
        ctl_facility = 1'b1;
        $display("test check conditions done");
        c = '0;
        c.addr = 24'h000200;
        c.cmd_low = 4'h1;
        c.count = 16'h0002;
        c.cmd_chain = 1'b1;
        run(c, CHSC_OP_WRITE, 2, 8'h4c, 1'b0, 8'h00, 1'b1);
        chk1(cg_seen, 1'b1);
        chk32({8'h00, chain_addr}, {8'h00, 24'h000200 + CCD_STEP_SKIP});
        $display("test modifier chain done");
        c.cmd_chain = 1'b0;
        c.data_chain = 1'b1;
        c.ppi_flag = 1'b1;
        run(c, CHSC_OP_READ, 2, 8'h0c, 1'b0, 8'h00, 1'b1);
        chk1(ppi_pending, 1'b1);
        c.cmd_chain = 1'b1;
        c.data_chain = 1'b0;
        run(c, CHSC_OP_READ, 2, 8'h0c, 1'b0, 8'h00, 1'b1);
        chk1(ppi_pending, 1'b1);
        run(c, CHSC_OP_READ, 0, 8'h40, 1'b1, 8'h00, 1'b0);
        chk32(status_word, 32'h00400000);
        chk1(ppi_pending, 1'b1);
        ppi_ack = 1'b1;
        tick();
        ppi_ack = 1'b0;
        repeat (2) tick();
        chk1(ppi_pending, 1'b0);
        $display("test post program interrupt done");
        report_and_stop();
    end
endmodule
